// >>> include/panel_pkg.sv
package panel_pkg;

  // Clock rate, 100 MHz
  localparam longint unsigned CLK_KHZ = 64'd100000;

  // Operator timing in milliseconds
  localparam longint unsigned IDLE_MS = 64'd60000;
  localparam longint unsigned FACTORY_MS = 64'd12000;
  localparam longint unsigned HOLD_MS = 64'd5000;
  localparam longint unsigned FLASH_MS = 64'd3000;
  localparam longint unsigned DEBOUNCE_MS = 64'd20;
  localparam longint unsigned BLINK_MS = 64'd250;

  // Same times as clock cycles
  localparam longint unsigned IDLE_CYC = IDLE_MS * CLK_KHZ;
  localparam longint unsigned FACTORY_CYC = FACTORY_MS * CLK_KHZ;
  localparam longint unsigned HOLD_CYC = HOLD_MS * CLK_KHZ;
  localparam longint unsigned FLASH_CYC = FLASH_MS * CLK_KHZ;
  localparam longint unsigned DEBOUNCE_CYC = DEBOUNCE_MS * CLK_KHZ;
  localparam longint unsigned BLINK_CYC = BLINK_MS * CLK_KHZ;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] MASK_OFS = 8'h08;

  // Control register field positions
  localparam int CTRL_RM_BIT = 0;
  localparam int CTRL_MR_BIT = 1;

  // Status register field positions
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_BTN_BIT = 2;
  localparam int STAT_FAULT_BIT = 3;
  localparam int STAT_MVALID_BIT = 4;
  localparam int STAT_START_BIT = 5;

  // Factory default settings
  localparam logic RM_EN_RST = 1'b0;
  localparam logic MR_EN_RST = 1'b0;
  localparam logic MASK_VALID_RST = 1'b0;

  // Display modes, Gray coded along A-B-C-D
  typedef enum logic [1:0] {
    MODE_A = 2'h0,
    MODE_B = 2'h1,
    MODE_C = 2'h3,
    MODE_D = 2'h2
  } disp_mode_t;

endpackage

// >>> hw/panel_ctrl.sv
`timescale 1ns/1ps

// Summary of operation
// - Short press steps mode A, B, C, D
// - One idle minute returns display to A
// - Mode LED off, green, orange, flashing
// - Twelve second hold in A: factory reset
// - Early release cancels the factory reset
// - Factory reset restores every default setting
// - Five second hold in A/D captures mask
// - Deviation from stored mask reports a fault
// - Mode LED flashes after three held seconds, except in C
// - Early release keeps the old mask
// - Five second hold in B toggles manager
// - Early release aborts the manager toggle
// - Enabling manager also enables media redundancy
// - Disabling manager leaves media redundancy unchanged
// - Ring LED off, steady, flashing on break
// - Standby LED off, steady passive, flashing active
// - Startup fault LED steady, flashing, then off
// - Operating error lights LED, opens contact
module panel_ctrl #(
  parameter int NPORT = 8,
  parameter int CW = 36,
  parameter logic [CW-1:0] IDLE_CYC = CW'(panel_pkg::IDLE_CYC),
  parameter logic [CW-1:0] FACTORY_CYC = CW'(panel_pkg::FACTORY_CYC),
  parameter logic [CW-1:0] HOLD_CYC = CW'(panel_pkg::HOLD_CYC),
  parameter logic [CW-1:0] FLASH_CYC = CW'(panel_pkg::FLASH_CYC),
  parameter logic [CW-1:0] DEBOUNCE_CYC = CW'(panel_pkg::DEBOUNCE_CYC),
  parameter logic [CW-1:0] BLINK_CYC = CW'(panel_pkg::BLINK_CYC)
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic btn_n,
  input wire logic [NPORT-1:0] port_link,
  input wire logic [1:0] psu_good,
  input wire logic ring_break,
  input wire logic standby_en,
  input wire logic standby_active,
  input wire logic startup_done,
  input wire logic fw_bad,
  input wire logic error_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic mode_indicator_led_green,
  output logic mode_indicator_led_orange,
  output logic ring_manager_led,
  output logic standby_led,
  output logic fault_led,
  output logic contact_open,
  output logic factory_reset,
  output logic rm_enable,
  output logic mr_enable,
  output logic [NPORT+1:0] fault_mask,
  output logic mask_valid
);

  localparam int MW = NPORT + 2;

  // All state of the block
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic deb;
    logic [CW-1:0] deb_cnt;
    logic [CW-1:0] hold_cnt;
    logic [CW-1:0] idle_cnt;
    logic [CW-1:0] blink_cnt;
    logic blink;
    logic done;
    panel_pkg::disp_mode_t mode;
    logic rm_en;
    logic mr_en;
    logic [MW-1:0] mask;
    logic mask_valid;
    logic factory;
    logic led_g;
    logic led_o;
    logic led_rm;
    logic led_sb;
    logic led_f;
    logic contact;
    logic [31:0] rdata;
  } state_t;

  state_t st_ff;
  state_t nxt_st;

  logic [MW-1:0] live;
  logic release_evt;
  logic rel_short;
  logic hit_hold;
  logic hit_factory;
  logic rm_take;
  logic mask_take;
  logic hold_flash;
  logic idle_to;
  logic fault_now;
  logic wr_acc;
  logic rd_setup;
  logic mapped;

  // Observed good-state vector: supplies above ports
  assign live = {psu_good, port_link};

  // Button events from the debounced level
  assign release_evt = !st_ff.deb && (st_ff.hold_cnt != '0);
  assign rel_short = release_evt && (st_ff.hold_cnt < FLASH_CYC);
  assign hit_hold = st_ff.deb && !st_ff.done && (st_ff.hold_cnt == HOLD_CYC - 1'b1);
  assign hit_factory = st_ff.deb && !st_ff.done && (st_ff.mode == panel_pkg::MODE_A)
    && (st_ff.hold_cnt == FACTORY_CYC - 1'b1);
  assign rm_take = hit_hold && (st_ff.mode == panel_pkg::MODE_B);
  // Mode D acts at five seconds; mode A acts on release between five and twelve
  assign mask_take = (hit_hold && (st_ff.mode == panel_pkg::MODE_D))
    || (release_evt && !st_ff.done && (st_ff.mode == panel_pkg::MODE_A)
        && (st_ff.hold_cnt >= HOLD_CYC));
  assign hold_flash = st_ff.deb && (st_ff.hold_cnt >= FLASH_CYC)
    && (st_ff.mode != panel_pkg::MODE_C);
  assign idle_to = st_ff.idle_cnt >= IDLE_CYC;
  assign fault_now = (st_ff.mask_valid && (live != st_ff.mask)) || error_in;

  // APB decode
  assign mapped = (paddr == panel_pkg::CTRL_OFS) || (paddr == panel_pkg::STATUS_OFS)
    || (paddr == panel_pkg::MASK_OFS);
  assign wr_acc = psel && penable && pwrite && mapped;
  assign rd_setup = psel && !penable;
  assign pready = psel && penable;
  assign pslverr = psel && penable && !mapped;

  // Next state
  always_comb begin
    nxt_st = st_ff;
    nxt_st.factory = 1'b0;
    // Two-flop synchroniser on the pin
    nxt_st.sync1 = btn_n;
    nxt_st.sync2 = st_ff.sync1;
    // Debounce: level must stay different for the whole window
    if ((!st_ff.sync2) != st_ff.deb) begin
      if (st_ff.deb_cnt >= DEBOUNCE_CYC - 1'b1) begin
        nxt_st.deb = !st_ff.sync2;
        nxt_st.deb_cnt = '0;
      end else begin
        nxt_st.deb_cnt = st_ff.deb_cnt + 1'b1;
      end
    end else begin
      nxt_st.deb_cnt = '0;
    end
    // Hold timer, saturating at the longest threshold
    if (st_ff.deb) begin
      if (st_ff.hold_cnt < FACTORY_CYC) begin
        nxt_st.hold_cnt = st_ff.hold_cnt + 1'b1;
      end
    end else begin
      nxt_st.hold_cnt = '0;
      nxt_st.done = 1'b0; // Release ends any pending action
    end
    // Idle timer, cleared by any press
    if (st_ff.deb) begin
      nxt_st.idle_cnt = '0;
    end else if (!idle_to) begin
      nxt_st.idle_cnt = st_ff.idle_cnt + 1'b1;
    end
    // Flash phase generator
    if (st_ff.blink_cnt >= BLINK_CYC - 1'b1) begin
      nxt_st.blink_cnt = '0;
      nxt_st.blink = !st_ff.blink;
    end else begin
      nxt_st.blink_cnt = st_ff.blink_cnt + 1'b1;
    end
    // Display mode stepping
    if (rel_short) begin
      case (st_ff.mode)
        panel_pkg::MODE_A: nxt_st.mode = panel_pkg::MODE_B;
        panel_pkg::MODE_B: nxt_st.mode = panel_pkg::MODE_C;
        panel_pkg::MODE_C: nxt_st.mode = panel_pkg::MODE_D;
        panel_pkg::MODE_D: nxt_st.mode = panel_pkg::MODE_A;
        default: nxt_st.mode = panel_pkg::MODE_A;
      endcase
    end else if (idle_to && !st_ff.deb) begin
      nxt_st.mode = panel_pkg::MODE_A;
    end
    // Software writes
    if (wr_acc && (paddr == panel_pkg::CTRL_OFS)) begin
      nxt_st.rm_en = pwdata[panel_pkg::CTRL_RM_BIT];
      nxt_st.mr_en = pwdata[panel_pkg::CTRL_MR_BIT];
    end
    if (wr_acc && (paddr == panel_pkg::MASK_OFS)) begin
      nxt_st.mask = pwdata[MW-1:0];
      nxt_st.mask_valid = 1'b1;
    end
    // Long-hold actions, button wins over a same-cycle write
    if (rm_take) begin
      nxt_st.done = 1'b1;
      nxt_st.rm_en = !st_ff.rm_en;
      if (!st_ff.rm_en && !st_ff.mr_en) begin
        nxt_st.mr_en = 1'b1;
      end else begin
        nxt_st.mr_en = st_ff.mr_en;
      end
    end
    if (mask_take) begin
      nxt_st.done = 1'b1;
      nxt_st.mask = live;
      nxt_st.mask_valid = 1'b1;
    end
    if (hit_factory) begin
      nxt_st.done = 1'b1;
      nxt_st.factory = 1'b1;
      nxt_st.rm_en = panel_pkg::RM_EN_RST;
      nxt_st.mr_en = panel_pkg::MR_EN_RST;
      nxt_st.mask = '0;
      nxt_st.mask_valid = panel_pkg::MASK_VALID_RST;
      nxt_st.mode = panel_pkg::MODE_A;
    end
    // Mode indicator
    if (hold_flash) begin
      nxt_st.led_g = st_ff.blink;
      nxt_st.led_o = 1'b0;
    end else begin
      case (st_ff.mode)
        panel_pkg::MODE_A: begin
          nxt_st.led_g = 1'b0;
          nxt_st.led_o = 1'b0;
        end
        panel_pkg::MODE_B: begin
          nxt_st.led_g = 1'b1;
          nxt_st.led_o = 1'b0;
        end
        panel_pkg::MODE_C: begin
          nxt_st.led_g = 1'b0;
          nxt_st.led_o = 1'b1;
        end
        panel_pkg::MODE_D: begin
          nxt_st.led_g = st_ff.blink;
          nxt_st.led_o = 1'b1;
        end
        default: begin
          nxt_st.led_g = 1'b0;
          nxt_st.led_o = 1'b0;
        end
      endcase
    end
    // Ring and standby indicators
    nxt_st.led_rm = st_ff.rm_en && (!ring_break || st_ff.blink);
    nxt_st.led_sb = standby_en && (!standby_active || st_ff.blink);
    // Fault indicator and signalling contact
    if (!startup_done) begin
      nxt_st.led_f = fw_bad ? st_ff.blink : 1'b1;
      nxt_st.contact = 1'b0;
    end else begin
      nxt_st.led_f = fault_now;
      nxt_st.contact = fault_now;
    end
    // Read data captured in the setup cycle
    if (rd_setup) begin
      nxt_st.rdata = '0;
      case (paddr)
        panel_pkg::CTRL_OFS: begin
          nxt_st.rdata[panel_pkg::CTRL_RM_BIT] = st_ff.rm_en;
          nxt_st.rdata[panel_pkg::CTRL_MR_BIT] = st_ff.mr_en;
        end
        panel_pkg::STATUS_OFS: begin
          nxt_st.rdata[panel_pkg::STAT_MODE_LSB +: 2] = st_ff.mode;
          nxt_st.rdata[panel_pkg::STAT_BTN_BIT] = st_ff.deb;
          nxt_st.rdata[panel_pkg::STAT_FAULT_BIT] = st_ff.contact;
          nxt_st.rdata[panel_pkg::STAT_MVALID_BIT] = st_ff.mask_valid;
          nxt_st.rdata[panel_pkg::STAT_START_BIT] = startup_done;
        end
        panel_pkg::MASK_OFS: nxt_st.rdata[MW-1:0] = st_ff.mask;
        default: nxt_st.rdata = '0;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= '0;
      st_ff.sync1 <= 1'b1;
      st_ff.sync2 <= 1'b1;
      st_ff.mode <= panel_pkg::MODE_A;
      st_ff.rm_en <= panel_pkg::RM_EN_RST;
      st_ff.mr_en <= panel_pkg::MR_EN_RST;
      st_ff.mask_valid <= panel_pkg::MASK_VALID_RST;
      st_ff.led_f <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs from flops
  assign prdata = st_ff.rdata;
  assign mode_indicator_led_green = st_ff.led_g;
  assign mode_indicator_led_orange = st_ff.led_o;
  assign ring_manager_led = st_ff.led_rm;
  assign standby_led = st_ff.led_sb;
  assign fault_led = st_ff.led_f;
  assign contact_open = st_ff.contact;
  assign factory_reset = st_ff.factory;
  assign rm_enable = st_ff.rm_en;
  assign mr_enable = st_ff.mr_en;
  assign fault_mask = st_ff.mask;
  assign mask_valid = st_ff.mask_valid;

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  a_mode_step: assert property (rel_short && st_ff.mode == panel_pkg::MODE_A |=> st_ff.mode == panel_pkg::MODE_B)
    else $error("short press in A did not reach B");
  a_mode_wrap: assert property (rel_short && st_ff.mode == panel_pkg::MODE_D |=> st_ff.mode == panel_pkg::MODE_A)
    else $error("short press in D did not return to A");
  a_idle_return: assert property (idle_to && !st_ff.deb && !rel_short |=> st_ff.mode == panel_pkg::MODE_A)
    else $error("idle timeout did not restore mode A");
  a_mode_led: assert property (st_ff.mode == panel_pkg::MODE_C && !hold_flash
    |=> !mode_indicator_led_green && mode_indicator_led_orange)
    else $error("mode C indicator wrong");
  a_factory_cause: assert property (factory_reset |-> $past(st_ff.mode) == panel_pkg::MODE_A
    && $past(st_ff.hold_cnt) == FACTORY_CYC - 1'b1)
    else $error("factory reset without twelve second hold in A");
  a_factory_cancel: assert property (factory_reset |-> $past(st_ff.deb, 1))
    else $error("factory reset after release");
  a_factory_dflt: assert property (factory_reset |-> !rm_enable && !mr_enable && !mask_valid)
    else $error("defaults not restored");
  a_mask_capture: assert property (mask_take |=> fault_mask == $past(live) && mask_valid)
    else $error("mask not captured");
  a_fault_report: assert property (startup_done && mask_valid && live != fault_mask |=> fault_led && contact_open)
    else $error("mask deviation not reported");
  a_hold_flash: assert property (st_ff.deb && st_ff.mode == panel_pkg::MODE_B && st_ff.hold_cnt >= FLASH_CYC
    && !st_ff.blink |=> !mode_indicator_led_green)
    else $error("indicator not flashing during hold");
  a_mask_keep: assert property (!mask_take && !hit_factory && !wr_acc |=> $stable(fault_mask))
    else $error("mask changed without capture");
  a_rm_toggle: assert property (rm_take |=> rm_enable != $past(rm_enable))
    else $error("manager not toggled");
  a_rm_abort: assert property (!rm_take && !hit_factory && !wr_acc |=> $stable(rm_enable))
    else $error("manager changed without action");
  a_mr_follow: assert property (rm_take && !rm_enable && !mr_enable |=> mr_enable)
    else $error("media redundancy not enabled");
  a_mr_keep: assert property (rm_take && rm_enable |=> mr_enable == $past(mr_enable))
    else $error("media redundancy changed on disable");
  a_rm_led: assert property (!rm_enable |=> !ring_manager_led)
    else $error("ring LED lit while not manager");
  a_sb_led: assert property (standby_en && !standby_active |=> standby_led)
    else $error("standby LED not steady");
  a_start_led: assert property (!startup_done && !fw_bad |=> fault_led)
    else $error("fault LED not steady in startup");
  a_start_contact: assert property (!startup_done |=> !contact_open)
    else $error("contact opened during startup");
  a_factory_pulse: assert property (factory_reset |=> !factory_reset)
    else $error("factory reset pulse longer than one cycle");
  a_mode_d_led: assert property (st_ff.mode == panel_pkg::MODE_D && !hold_flash
    |=> mode_indicator_led_orange && mode_indicator_led_green == $past(st_ff.blink))
    else $error("mode D indicator not flashing");
  a_long_no_step: assert property (release_evt && st_ff.hold_cnt >= FLASH_CYC |=> $stable(st_ff.mode))
    else $error("long hold stepped the display mode");
  a_rm_led_flash: assert property (rm_enable && ring_break && !st_ff.blink |=> !ring_manager_led)
    else $error("ring LED not flashing on break");

  c_short_press: cover property (rel_short);
  c_rm_toggle: cover property (rm_take);
  c_mask_take: cover property (mask_take);
  c_factory: cover property (factory_reset);

endmodule

// >>> tb/button_operator.sv
`timescale 1ns/1ps

// Operator at the push button; the pin idles high through its pull-up
module button_operator (
  input wire logic clk_sys,
  output logic btn_n
);
  initial btn_n = 1'h1;

  // Press for n cycles without a break, then let go and allow settling
  task automatic press(input int n);
    @(posedge clk_sys);
    btn_n <= 1'h0;
    repeat (n) @(posedge clk_sys);
    btn_n <= 1'h1;
    repeat (14) @(posedge clk_sys);
  endtask
endmodule

// >>> tb/tb_button_display_mode_control.sv
`timescale 1ns/1ps

module tb_button_display_mode_control;
  // Hold lengths against flash 30, action 50, factory 120 cycles
  localparam int SHORT = 10, MID = 48, LONG = 70, NEARF = 90, FULL = 140;
  // Shortened timing: hold thresholds at one hundredth of their millisecond figures, idle at 400 cycles, fast debounce and blink
  localparam logic [35:0] IDLE_T = 36'h190, DEB_T = 36'h3, BLINK_T = 36'h4;
  localparam logic [35:0] FACT_T = 36'(panel_pkg::FACTORY_MS / 64'd100);
  localparam logic [35:0] HOLD_T = 36'(panel_pkg::HOLD_MS / 64'd100);
  localparam logic [35:0] FLASH_T = 36'(panel_pkg::FLASH_MS / 64'd100);
  logic clk_sys = 1'h0;
  logic sys_rst = 1'h1;
  logic btn_n;
  logic [7:0] port_link = 8'h00;
  logic [1:0] psu_good = 2'h0;
  logic ring_break = 1'h0, standby_en = 1'h0, standby_active = 1'h0;
  logic startup_done = 1'h0, fw_bad = 1'h0, error_in = 1'h0;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, e, mig, mio, ring_manager_led, standby_led, fault_led;
  logic contact_open, factory_reset, rm_enable, mr_enable, mask_valid;
  logic [9:0] fault_mask;
  wire [4:0] leds = {fault_led, standby_led, ring_manager_led, mio, mig};
  int mismatches = 0, total_checks = 0, fr_cnt = 0, cyc = 0;

  always #5 clk_sys = ~clk_sys;

  // Factory pulse count and hang limit
  always @(posedge clk_sys) begin
    cyc++;
    fr_cnt += (factory_reset === 1'h1);
    if (cyc == 8000) begin
      mismatches++;
      end_of_test();
    end
  end

  button_operator op_u (.clk_sys, .btn_n);

  panel_ctrl #(.IDLE_CYC(IDLE_T), .FACTORY_CYC(FACT_T), .HOLD_CYC(HOLD_T), .FLASH_CYC(FLASH_T),
    .DEBOUNCE_CYC(DEB_T), .BLINK_CYC(BLINK_T)) dut_u (
    .clk_sys, .sys_rst, .btn_n, .port_link, .psu_good, .ring_break, .standby_en, .standby_active,
    .startup_done, .fw_bad, .error_in, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .mode_indicator_led_green(mig), .mode_indicator_led_orange(mio), .ring_manager_led,
    .standby_led, .fault_led, .contact_open, .factory_reset, .rm_enable, .mr_enable, .fault_mask,
    .mask_valid);

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (g !== x) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, x, g);
    end
  endtask

  // One APB transfer, held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'h1;
    do @(posedge clk_sys); while (pready !== 1'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  // Lamp class over 12 cycles: 0 off, 1 steady, 2 flashing
  task automatic lamp(input int i, input logic [1:0] k);
    int n;
    int u;
    n = 0;
    u = 0;
    repeat (3) @(posedge clk_sys);
    repeat (12) begin
      @(posedge clk_sys);
      n += (leds[i] === 1'h1);
      u += $isunknown(leds[i]);
    end
    // An unknown lamp level is its own class and never passes
    chk($sformatf("lamp%0d", i), k, (u != 0) ? 2'h3 : (n == 0) ? 2'h0 : (n == 12) ? 2'h1 : 2'h2);
  endtask

  task automatic chkmode(input logic [1:0] m, input logic [1:0] g, input logic [1:0] o);
    apb(1'h0, panel_pkg::STATUS_OFS, 32'h0);
    chk("mode", m, q[1:0]);
    lamp(0, g);
    lamp(1, o);
  endtask

  task automatic t_start();
    chk("fault", 1'h1, fault_led);
    fw_bad <= 1'h1;
    lamp(4, 2'h2);
    fw_bad <= 1'h0;
    lamp(4, 2'h1);
    startup_done <= 1'h1;
    lamp(4, 2'h0);
    chk("contact", 1'h0, contact_open);
  endtask

  task automatic t_modes();
    chkmode(panel_pkg::MODE_A, 2'h0, 2'h0);
    op_u.press(SHORT);
    chkmode(panel_pkg::MODE_B, 2'h1, 2'h0);
    op_u.press(SHORT);
    chkmode(panel_pkg::MODE_C, 2'h0, 2'h1);
    op_u.press(SHORT);
    chkmode(panel_pkg::MODE_D, 2'h2, 2'h1);
    op_u.press(SHORT);
    chkmode(panel_pkg::MODE_A, 2'h0, 2'h0);
  endtask

  task automatic t_idle();
    op_u.press(SHORT);
    chkmode(panel_pkg::MODE_B, 2'h1, 2'h0);
    repeat (390) @(posedge clk_sys);
    chkmode(panel_pkg::MODE_A, 2'h0, 2'h0);
  endtask

  // Manager toggle in mode B, early release first
  task automatic t_rm();
    op_u.press(SHORT);
    fork
      op_u.press(MID);
      begin
        repeat (35) @(posedge clk_sys);
        lamp(0, 2'h2);
      end
    join
    chk("rm", 1'h0, rm_enable);
    chk("mr", 1'h0, mr_enable);
    op_u.press(LONG);
    chk("rm", 1'h1, rm_enable);
    chk("mr", 1'h1, mr_enable);
    lamp(2, 2'h1);
    ring_break <= 1'h1;
    lamp(2, 2'h2);
    ring_break <= 1'h0;
    op_u.press(LONG);
    chk("rm", 1'h0, rm_enable);
    chk("mr", 1'h1, mr_enable);
    lamp(2, 2'h0);
    chkmode(panel_pkg::MODE_B, 2'h1, 2'h0);
  endtask

  task automatic t_sb();
    lamp(3, 2'h0);
    standby_en <= 1'h1;
    lamp(3, 2'h1);
    standby_active <= 1'h1;
    lamp(3, 2'h2);
    standby_en <= 1'h0;
    standby_active <= 1'h0;
  endtask

  // Mask capture in mode D, then deviations
  task automatic t_mask();
    op_u.press(SHORT);
    op_u.press(SHORT);
    port_link <= 8'hA5;
    psu_good <= 2'h3;
    op_u.press(LONG);
    chk("mask", 10'h3A5, fault_mask);
    chk("mvalid", 1'h1, mask_valid);
    lamp(4, 2'h0);
    port_link <= 8'hA4;
    lamp(4, 2'h1);
    chk("contact", 1'h1, contact_open);
    op_u.press(MID);
    chk("mask", 10'h3A5, fault_mask);
    port_link <= 8'hA5;
    lamp(4, 2'h0);
    error_in <= 1'h1;
    lamp(4, 2'h1);
    chk("contact", 1'h1, contact_open);
    error_in <= 1'h0;
  endtask

  task automatic t_factory();
    op_u.press(SHORT);
    chkmode(panel_pkg::MODE_A, 2'h0, 2'h0);
    apb(1'h1, panel_pkg::CTRL_OFS, 32'h1);
    op_u.press(NEARF);
    chk("frst", 0, fr_cnt);
    chk("rm", 1'h1, rm_enable);
    op_u.press(FULL);
    chk("frst", 1, fr_cnt);
    chk("rm", panel_pkg::RM_EN_RST, rm_enable);
    chk("mr", panel_pkg::MR_EN_RST, mr_enable);
    chk("mvalid", panel_pkg::MASK_VALID_RST, mask_valid);
    chk("mask", 10'h000, fault_mask);
  endtask

  task automatic t_regs();
    apb(1'h1, panel_pkg::CTRL_OFS, 32'h3);
    apb(1'h0, panel_pkg::CTRL_OFS, 32'h0);
    chk("ctrl", 32'h3, q);
    apb(1'h1, panel_pkg::STATUS_OFS, 32'hFF);
    chk("serr", 1'h0, e);
    apb(1'h0, 8'h0C, 32'h0);
    chk("serr", 1'h1, e);
    apb(1'h1, panel_pkg::MASK_OFS, 32'h155);
    apb(1'h0, panel_pkg::MASK_OFS, 32'h0);
    chk("maskrd", 32'h155, q);
    chk("mask", 10'h155, fault_mask);
    chk("mvalid", 1'h1, mask_valid);
    apb(1'h0, panel_pkg::STATUS_OFS, 32'h0);
    chk("status", 32'h38, q);
  endtask

  initial begin
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'h0;
    t_start();
    t_modes();
    t_idle();
    t_rm();
    t_sb();
    t_mask();
    t_factory();
    t_regs();
    end_of_test();
  end
endmodule
